/* logic/iet_params.svh */
// timing constants for the instruction execution cycle model
`ifndef IET_PARAMS_SVH
`define IET_PARAMS_SVH
`define IET_CLK_PERIOD_NS   8
`define IET_BUS_CLKS        4'h2
`define IET_LONG_EXTRA      8'h02
`define IET_SHIFT_MIN       8'h06
`define IET_ROXR_MAX        6'h3F
`define IET_ROXI_MAX        6'h08
`define IET_BR_TAKEN        8'h08
`define IET_BR_TAKEN_TAIL   8'hFE
`define IET_BR_B_UNTAKEN    8'h04
`define IET_BR_W_UNTAKEN    8'h04
`define IET_BR_L_UNTAKEN    8'h06
`define IET_DB_TRUE         8'h04
`define IET_DB_EXPIRE       8'h06
`define IET_DB_BACK         8'h0A
`define IET_LDB_TRUE        8'h06
`define IET_LDB_EXPIRE      8'h08
`define IET_LDB_BACK        8'h06
`endif

/* logic/iet_pkg.sv */
// types for the instruction execution cycle model
`default_nettype none
package iet_pkg;
	typedef enum logic [4:0] {
		IET_CLEAR, IET_NEGATE, IET_NEGATE_WITH_EXTEND_OP, IET_COMPLEMENT, IET_SIGN_EXTEND,
		IET_DECIMAL_NEGATE, IET_COND_SET, IET_TEST_AND_SET, IET_OPERAND_TEST,
		IET_LOGICAL_SHIFT, IET_ARITH_SHIFT, IET_PLAIN_ROTATE, IET_ROTATE_X,
		IET_BIT_CHANGE, IET_BIT_CLEAR, IET_BIT_SET, IET_BIT_TEST,
		IET_BRANCH, IET_DEC_BRANCH
	} iet_op_t;
	typedef enum logic [1:0] {IET_SZ_BYTE, IET_SZ_WORD, IET_SZ_LONG} iet_size_t;
	typedef enum logic [1:0] {IET_IDLE, IET_RUN, IET_WAIT_BUS} iet_state_t;
endpackage : iet_pkg
`default_nettype wire

/* logic/iet_bus_if.sv */
// bus-stretch counting link between the timing model and its bus monitor
`timescale 1ns/1ps
`default_nettype none
interface iet_bus_if;
	logic       cycle_done;
	logic [3:0] cycle_clks;
	logic [7:0] stretch_total;
	logic       clear;
	modport mon (input cycle_done, input cycle_clks, input clear, output stretch_total);
	modport core (output cycle_done, output cycle_clks, output clear, input stretch_total);
endinterface : iet_bus_if
`default_nettype wire

/* logic/iet_bus_stretch.sv */
// accumulates clocks that bus cycles take beyond the two-clock assumption
`timescale 1ns/1ps
`default_nettype none
`include "iet_params.svh"
module iet_bus_stretch (
	input  wire logic clk_in,
	input  wire logic resetn_in,
	iet_bus_if.mon    bus
);
	logic [7:0] acc_q;
	logic [7:0] extra_w;
	assign extra_w = (bus.cycle_clks > `IET_BUS_CLKS) ?
		{4'h0, 4'(bus.cycle_clks - `IET_BUS_CLKS)} : 8'h00;
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) acc_q <= 8'h00;
		else if (bus.clear) acc_q <= 8'h00;
		else if (bus.cycle_done) acc_q <= 8'(acc_q + extra_w);
	end
	assign bus.stretch_total = acc_q;
endmodule : iet_bus_stretch
`default_nettype wire

/* logic/iet_exec_timing.sv */
// cycle-count model for single-operand, shift, bit and branch instructions
`timescale 1ns/1ps
`default_nettype none
`include "iet_params.svh"
// Overview of operation
// - totals assume two-clock bus cycles; slower cycles ending after the start edge and before the finishing edge add their extra clocks.
// - memory clear, negate, negate-extend or complement use one bus cycle for byte or word and two for long; bit test, extend and test use none, others one.
// - a long memory clear, negate, negate-extend or complement adds two clocks to both tail and total.
// - each total includes the reads, prefetches and writes reported beside it.
// - shift time ignores the count except for the formula-timed forms.
// - register-count shifts and plain rotates use the stepped formula with minimum 6.
// - register-count rotate-through-extend takes max(6, 3+n+(n even)).
// - immediate rotate-through-extend takes max(6, 2+n+(n odd)).
// - immediate shifts on a register take 6(0/1/0); memory shifts take 6(0/1/1).
// - clear, negate, negate-extend, complement, extend and test on a register take 2(0/1/0).
// - negate, negate-extend and complement on memory take 5(0/1/x); clear takes 4(0/1/x).
// - bit change/clear/set take 6 or 8 with a write; bit test takes 4 without write.
// - taken branch 8(0/2/0) tail -2; untaken byte, word, long 4, 4, 6.
// - outside loop mode decrement-branch takes 4 true, 6 expired, 10 back.
module iet_exec_timing (
	input  wire logic               clk_in,
	input  wire logic               resetn_in,
	input  wire logic               start_in,
	input  wire iet_pkg::iet_op_t   op_in,
	input  wire iet_pkg::iet_size_t size_in,
	input  wire logic               mem_operand_in,
	input  wire logic               count_in_reg_in,
	input  wire logic [5:0]         shift_count_in,
	input  wire logic               branch_taken_in,
	input  wire logic [1:0]         branch_size_in,
	input  wire logic               cond_true_in,
	input  wire logic               counter_expired_in,
	input  wire logic               loop_mode_in,
	input  wire logic               bus_cycle_done_in,
	input  wire logic [3:0]         bus_cycle_clks_in,
	output logic                    busy_out,
	output logic                    done_out,
	output logic [7:0]              total_out,
	output logic [7:0]              head_out,
	output logic [7:0]              tail_out,
	output logic [3:0]              reads_out,
	output logic [3:0]              prefetch_out,
	output logic [3:0]              writes_out
);
	iet_bus_if bus ();
	iet_bus_stretch u_stretch (.clk_in(clk_in), .resetn_in(resetn_in), .bus(bus));

	function automatic logic [7:0] max6(input logic [7:0] v);
		max6 = (v > `IET_SHIFT_MIN) ? v : `IET_SHIFT_MIN;
	endfunction : max6

	logic [7:0] n_w, q_w, r_w, f_std_w, f_roxr_w, f_roxi_w;
	assign n_w = {2'h0, shift_count_in};
	assign q_w = {4'h0, n_w[5:2]};
	assign r_w = {6'h00, n_w[1:0]};
	assign f_std_w  = max6(8'(8'h03 + q_w + r_w + {7'h00, ~(q_w[0] ^ r_w[0])}));
	assign f_roxr_w = max6(8'(8'h03 + n_w + {7'h00, ~n_w[0]}));
	assign f_roxi_w = max6(8'(8'h02 + n_w + {7'h00, n_w[0]}));

	logic       long_mem_w;
	logic [3:0] xw_w;
	assign long_mem_w = mem_operand_in && (size_in == iet_pkg::IET_SZ_LONG);
	assign xw_w = long_mem_w ? 4'h2 : 4'h1;

	logic [7:0] t_d, h_d, tl_d;
	logic [3:0] p_d, w_d;
	always_comb begin
		t_d = 8'h02;
		h_d = 8'h00;
		tl_d = 8'h00;
		p_d = 4'h1;
		w_d = 4'h0;
		unique case (op_in)
			iet_pkg::IET_CLEAR: if (mem_operand_in) begin
				t_d = 8'h04; tl_d = 8'h02; w_d = xw_w;
			end
			iet_pkg::IET_NEGATE, iet_pkg::IET_NEGATE_WITH_EXTEND_OP, iet_pkg::IET_COMPLEMENT:
				if (mem_operand_in) begin
					t_d = 8'h05; tl_d = 8'h03; w_d = xw_w;
				end
			iet_pkg::IET_SIGN_EXTEND, iet_pkg::IET_OPERAND_TEST: t_d = 8'h02;
			iet_pkg::IET_DECIMAL_NEGATE: if (mem_operand_in) begin
				t_d = 8'h06; tl_d = 8'h02; w_d = 4'h1;
			end else begin
				t_d = 8'h04; h_d = 8'h02;
			end
			iet_pkg::IET_COND_SET: if (mem_operand_in) begin
				t_d = 8'h06; h_d = 8'h02; tl_d = 8'h02; w_d = 4'h1;
			end else begin
				t_d = 8'h04; h_d = 8'h02;
			end
			iet_pkg::IET_TEST_AND_SET: if (mem_operand_in) begin
				t_d = 8'h0A; h_d = 8'h01; w_d = 4'h1;
			end else begin
				t_d = 8'h06; h_d = 8'h04;
			end
			iet_pkg::IET_LOGICAL_SHIFT, iet_pkg::IET_ARITH_SHIFT,
			iet_pkg::IET_PLAIN_ROTATE, iet_pkg::IET_ROTATE_X: begin
				if (mem_operand_in) begin
					t_d = `IET_SHIFT_MIN; tl_d = 8'h02; w_d = 4'h1;
				end else if (op_in == iet_pkg::IET_ROTATE_X) begin
					t_d = count_in_reg_in ? f_roxr_w : f_roxi_w;
					h_d = `IET_BR_TAKEN_TAIL;
				end else if (count_in_reg_in) begin
					t_d = f_std_w; h_d = `IET_BR_TAKEN_TAIL;
				end else begin
					t_d = `IET_SHIFT_MIN; h_d = 8'h04;
				end
			end
			iet_pkg::IET_BIT_CHANGE, iet_pkg::IET_BIT_CLEAR, iet_pkg::IET_BIT_SET: begin
				p_d = count_in_reg_in ? 4'h1 : 4'h2;
				if (mem_operand_in) begin
					t_d = 8'h08; tl_d = 8'h02; w_d = 4'h1;
					h_d = count_in_reg_in ? 8'h02 : 8'h01;
				end else begin
					t_d = 8'h06; h_d = count_in_reg_in ? 8'h04 : 8'h02;
				end
			end
			iet_pkg::IET_BIT_TEST: begin
				t_d = 8'h04; p_d = count_in_reg_in ? 4'h1 : 4'h2;
				h_d = (mem_operand_in && !count_in_reg_in) ? 8'h01 : 8'h02;
			end
			iet_pkg::IET_BRANCH: if (branch_taken_in) begin
				t_d = `IET_BR_TAKEN; p_d = 4'h2; h_d = 8'h02; tl_d = `IET_BR_TAKEN_TAIL;
			end else begin
				unique case (branch_size_in)
					2'h0: begin t_d = `IET_BR_B_UNTAKEN; h_d = 8'h02; end
					2'h1: begin t_d = `IET_BR_W_UNTAKEN; p_d = 4'h2; end
					default: begin t_d = `IET_BR_L_UNTAKEN; p_d = 4'h3; end
				endcase
			end
			iet_pkg::IET_DEC_BRANCH: if (loop_mode_in) begin
				if (cond_true_in) begin
					t_d = `IET_LDB_TRUE; h_d = 8'h04;
				end else if (counter_expired_in) begin
					t_d = `IET_LDB_EXPIRE; h_d = 8'h06;
				end else begin
					t_d = `IET_LDB_BACK; h_d = 8'h06; p_d = 4'h0;
				end
			end else begin
				p_d = 4'h2;
				if (cond_true_in) begin
					t_d = `IET_DB_TRUE; h_d = 8'h01; tl_d = 8'h01;
				end else if (counter_expired_in) begin
					t_d = `IET_DB_EXPIRE; h_d = 8'h02;
				end else begin
					t_d = `IET_DB_BACK; h_d = 8'h06; tl_d = `IET_BR_TAKEN_TAIL;
				end
			end
			default: t_d = 8'h02;
		endcase
		if (long_mem_w && (w_d == 4'h2)) begin
			t_d = 8'(t_d + `IET_LONG_EXTRA);
			tl_d = 8'(tl_d + `IET_LONG_EXTRA);
		end
	end

	iet_pkg::iet_state_t st_q;
	logic [7:0] base_q, cnt_q, tl_q, h_q;
	logic [3:0] p_q, w_q;
	logic       done_q;
	logic [7:0] final_w;
	assign final_w = 8'(base_q + bus.stretch_total);
	// a cycle ending on the finishing edge is left out: the result is latched there
	assign bus.cycle_done = bus_cycle_done_in && (st_q != iet_pkg::IET_IDLE)
		&& (cnt_q < final_w);
	assign bus.cycle_clks = bus_cycle_clks_in;
	assign bus.clear = start_in && (st_q == iet_pkg::IET_IDLE);

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			st_q <= iet_pkg::IET_IDLE;
			base_q <= 8'h00; cnt_q <= 8'h00; tl_q <= 8'h00; h_q <= 8'h00;
			p_q <= 4'h0; w_q <= 4'h0; done_q <= 1'b0;
			total_out <= 8'h00; head_out <= 8'h00; tail_out <= 8'h00;
			reads_out <= 4'h0; prefetch_out <= 4'h0; writes_out <= 4'h0;
		end else begin
			done_q <= 1'b0;
			unique case (st_q)
				iet_pkg::IET_IDLE: if (start_in) begin
					base_q <= t_d; h_q <= h_d; tl_q <= tl_d; p_q <= p_d; w_q <= w_d;
					cnt_q <= 8'h01;
					st_q <= iet_pkg::IET_RUN;
				end
				iet_pkg::IET_RUN, iet_pkg::IET_WAIT_BUS: begin
					if (cnt_q < final_w) cnt_q <= 8'(cnt_q + 8'h01);
					else begin
						st_q <= iet_pkg::IET_IDLE;
						done_q <= 1'b1;
						total_out <= final_w;
						head_out <= h_q;
						tail_out <= 8'(tl_q + bus.stretch_total);
						reads_out <= 4'h0;
						prefetch_out <= p_q;
						writes_out <= w_q;
					end
				end
				default: st_q <= iet_pkg::IET_IDLE;
			endcase
		end
	end
	assign busy_out = (st_q != iet_pkg::IET_IDLE);
	assign done_out = done_q;

	AST_DONE_TOTAL: assert property (@(posedge clk_in) disable iff (!resetn_in)
		$rose(done_q) |-> total_out == final_w)
		else $error("total differs from counted clocks");
	AST_SHIFT_MIN: assert property (@(posedge clk_in) disable iff (!resetn_in)
		(n_w < 8'h03) |-> (f_std_w == `IET_SHIFT_MIN && f_roxr_w == `IET_SHIFT_MIN
		 && f_roxi_w == `IET_SHIFT_MIN))
		else $error("shift time below minimum");
	AST_ROXR: assert property (@(posedge clk_in) disable iff (!resetn_in)
		(n_w == 8'h3F) |-> f_roxr_w == 8'h42)
		else $error("register rotate-extend time wrong");
	AST_ROXI: assert property (@(posedge clk_in) disable iff (!resetn_in)
		(n_w == 8'h07) |-> f_roxi_w == 8'h0A)
		else $error("immediate rotate-extend time wrong");
	AST_STD7: assert property (@(posedge clk_in) disable iff (!resetn_in)
		(n_w == 8'h07) |-> f_std_w == 8'h08)
		else $error("stepped shift time wrong");
	AST_LONG: assert property (@(posedge clk_in) disable iff (!resetn_in)
		(op_in == iet_pkg::IET_NEGATE && long_mem_w) |-> t_d == 8'h07)
		else $error("long operand extra clocks missing");
	AST_LOOP_BACK: assert property (@(posedge clk_in) disable iff (!resetn_in)
		(op_in == iet_pkg::IET_DEC_BRANCH && loop_mode_in && !cond_true_in
		 && !counter_expired_in) |-> (t_d == 8'h06 && p_d == 4'h0))
		else $error("loop mode branch back wrong");
	AST_DB_BACK: assert property (@(posedge clk_in) disable iff (!resetn_in)
		(op_in == iet_pkg::IET_DEC_BRANCH && !loop_mode_in && !cond_true_in
		 && !counter_expired_in) |-> t_d == 8'h0A)
		else $error("decrement branch back wrong");
	AST_RUN_LEN: assert property (@(posedge clk_in) disable iff (!resetn_in)
		(start_in && !busy_out && op_in == iet_pkg::IET_OPERAND_TEST && !mem_operand_in
		 && !bus_cycle_done_in) |=> busy_out ##1 busy_out ##1 done_out)
		else $error("two-clock op length wrong");
endmodule : iet_exec_timing
`default_nettype wire

/* bench/iet_bus_model.sv */
// memory bus partner: finishes one bus cycle of a chosen length per request
`timescale 1ns/1ps
`default_nettype none
module iet_bus_model (
	input  wire logic       clk_in,
	input  wire logic       req_in,
	input  wire logic [3:0] len_in,
	output logic            done_out,
	output logic [3:0]      clks_out
);
	logic [3:0] left_q = 4'h0;
	initial begin
		done_out = 1'b0;
		clks_out = 4'hF;
	end
	always @(posedge clk_in) begin
		done_out <= 1'b0;
		// length is only valid with the pulse, so show a different value off it
		clks_out <= ~len_in;
		if (req_in && left_q == 4'h0) begin
			left_q <= len_in;
		end else if (left_q == 4'h1) begin
			left_q <= 4'h0;
			done_out <= 1'b1;
			clks_out <= len_in;
		end else if (left_q != 4'h0) begin
			left_q <= left_q - 4'h1;
		end
	end
endmodule : iet_bus_model
`default_nettype wire

/* bench/instr_exec_cycle_timing_tb.sv */
// self-checking bench for the instruction execution cycle model
`timescale 1ns/1ps
`default_nettype none
module instr_exec_cycle_timing_tb;
	logic               clk_in = 1'b0;
	logic               resetn_in = 1'b0;
	logic               start = 1'b0;
	logic               mem = 1'b0;
	logic               rg = 1'b0;
	logic               tk = 1'b0;
	logic               ct = 1'b0;
	logic               ex = 1'b0;
	logic               lp = 1'b0;
	logic               req = 1'b0;
	logic               bdone;
	logic               busy;
	logic               done;
	iet_pkg::iet_op_t   op = iet_pkg::IET_CLEAR;
	iet_pkg::iet_size_t sz = iet_pkg::IET_SZ_BYTE;
	logic [5:0]         cnt = 6'h00;
	logic [1:0]         bsz = 2'h0;
	logic [3:0]         bclks;
	logic [3:0]         rd;
	logic [3:0]         pf;
	logic [3:0]         wr;
	logic [7:0]         tot;
	logic [7:0]         hd;
	logic [7:0]         tl;
	int                 n_errors = 0;
	int                 n_compared = 0;
	int                 n;
	always #4 clk_in = ~clk_in;
	iet_bus_model iet_bus_model_inst (.clk_in(clk_in), .req_in(req), .len_in(4'h4),
		.done_out(bdone), .clks_out(bclks));
	iet_exec_timing iet_exec_timing_inst (.clk_in(clk_in), .resetn_in(resetn_in),
		.start_in(start), .op_in(op), .size_in(sz), .mem_operand_in(mem),
		.count_in_reg_in(rg), .shift_count_in(cnt), .branch_taken_in(tk),
		.branch_size_in(bsz), .cond_true_in(ct), .counter_expired_in(ex),
		.loop_mode_in(lp), .bus_cycle_done_in(bdone), .bus_cycle_clks_in(bclks),
		.busy_out(busy), .done_out(done), .total_out(tot), .head_out(hd), .tail_out(tl),
		.reads_out(rd), .prefetch_out(pf), .writes_out(wr));
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic close_out();
		$display("errors %0d compared %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : close_out
	// fields other than op, operand kind and count are set by the caller beforehand
	task automatic go(input iet_pkg::iet_op_t o, input logic m, input logic [5:0] c);
		@(posedge clk_in);
		op <= o;
		mem <= m;
		cnt <= c;
		start <= 1'b1;
		@(posedge clk_in);
		start <= 1'b0;
		n = 0;
		do begin
			@(posedge clk_in);
			n++;
			#1;
			if (n == 1) check("busy", {7'h00, busy}, 8'h01);
		end while (done !== 1'b1 && n < 300);
		if (n >= 300) begin
			n_errors++;
			close_out();
		end
		check("idle", {7'h00, busy}, 8'h00);
		// return on an edge so callers change fields there by non-blocking assignment
		@(posedge clk_in);
	endtask : go
	task automatic res(input logic [7:0] t, h, e, input logic [3:0] p, w);
		check("cycles", n[7:0], t);
		check("total", tot, t);
		check("head", hd, h);
		check("tail", tl, e);
		check("prefetch", {4'h0, pf}, {4'h0, p});
		check("writes", {4'h0, wr}, {4'h0, w});
		check("reads", {4'h0, rd}, 8'h00);
	endtask : res
	function automatic logic [7:0] mx6(input int q);
		return (q > 6) ? q[7:0] : 8'h06;
	endfunction : mx6
	task automatic t_single();
		iet_pkg::iet_op_t l[6] = '{iet_pkg::IET_CLEAR, iet_pkg::IET_NEGATE, iet_pkg::IET_NEGATE_WITH_EXTEND_OP,
			iet_pkg::IET_COMPLEMENT, iet_pkg::IET_SIGN_EXTEND, iet_pkg::IET_OPERAND_TEST};
		foreach (l[i]) begin
			go(l[i], 1'b0, 6'h00);
			res(8'h02, 8'h00, 8'h00, 4'h1, 4'h0);
		end
		sz <= iet_pkg::IET_SZ_LONG;
		go(iet_pkg::IET_NEGATE, 1'b1, 6'h00);
		res(8'h07, 8'h00, 8'h05, 4'h1, 4'h2);
		sz <= iet_pkg::IET_SZ_WORD;
		go(iet_pkg::IET_CLEAR, 1'b1, 6'h00);
		res(8'h04, 8'h00, 8'h02, 4'h1, 4'h1);
		go(iet_pkg::IET_COMPLEMENT, 1'b1, 6'h00);
		res(8'h05, 8'h00, 8'h03, 4'h1, 4'h1);
		go(iet_pkg::IET_DECIMAL_NEGATE, 1'b0, 6'h00);
		res(8'h04, 8'h02, 8'h00, 4'h1, 4'h0);
		go(iet_pkg::IET_COND_SET, 1'b1, 6'h00);
		res(8'h06, 8'h02, 8'h02, 4'h1, 4'h1);
		go(iet_pkg::IET_TEST_AND_SET, 1'b0, 6'h00);
		res(8'h06, 8'h04, 8'h00, 4'h1, 4'h0);
		go(iet_pkg::IET_TEST_AND_SET, 1'b1, 6'h00);
		res(8'h0A, 8'h01, 8'h00, 4'h1, 4'h1);
	endtask : t_single
	task automatic t_shift();
		iet_pkg::iet_op_t l[4] = '{iet_pkg::IET_LOGICAL_SHIFT, iet_pkg::IET_ARITH_SHIFT,
			iet_pkg::IET_PLAIN_ROTATE, iet_pkg::IET_ROTATE_X};
		int c[3] = '{0, 7, 63};
		foreach (l[i]) begin
			go(l[i], 1'b1, 6'h05);
			res(8'h06, 8'h00, 8'h02, 4'h1, 4'h1);
			foreach (c[k]) begin
				rg <= 1'b1;
				go(l[i], 1'b0, c[k][5:0]);
				if (i < 3) res(mx6(3 + c[k] / 4 + c[k] % 4 + (c[k] / 4 + c[k] % 4 + 1) % 2),
					8'hFE, 8'h00, 4'h1, 4'h0);
				else res(mx6(3 + c[k] + (c[k] + 1) % 2), 8'hFE, 8'h00, 4'h1, 4'h0);
				rg <= 1'b0;
				go(l[i], 1'b0, (k == 2) ? 6'h08 : c[k][5:0]);
				if (i < 3) res(8'h06, 8'h04, 8'h00, 4'h1, 4'h0);
				else res(mx6(2 + ((k == 2) ? 8 : c[k]) + ((k == 2) ? 0 : c[k] % 2)),
					8'hFE, 8'h00, 4'h1, 4'h0);
			end
		end
	endtask : t_shift
	task automatic t_bits();
		iet_pkg::iet_op_t l[3] = '{iet_pkg::IET_BIT_CHANGE, iet_pkg::IET_BIT_CLEAR,
			iet_pkg::IET_BIT_SET};
		foreach (l[i]) begin
			go(l[i], 1'b0, 6'h03);
			res(8'h06, 8'h02, 8'h00, 4'h2, 4'h0);
			go(l[i], 1'b1, 6'h03);
			res(8'h08, 8'h01, 8'h02, 4'h2, 4'h1);
		end
		go(iet_pkg::IET_BIT_TEST, 1'b0, 6'h03);
		res(8'h04, 8'h02, 8'h00, 4'h2, 4'h0);
		go(iet_pkg::IET_BIT_TEST, 1'b1, 6'h03);
		res(8'h04, 8'h01, 8'h00, 4'h2, 4'h0);
		rg <= 1'b1;
		go(iet_pkg::IET_BIT_SET, 1'b0, 6'h03);
		res(8'h06, 8'h04, 8'h00, 4'h1, 4'h0);
		go(iet_pkg::IET_BIT_CLEAR, 1'b1, 6'h03);
		res(8'h08, 8'h02, 8'h02, 4'h1, 4'h1);
		go(iet_pkg::IET_BIT_TEST, 1'b1, 6'h03);
		res(8'h04, 8'h02, 8'h00, 4'h1, 4'h0);
		rg <= 1'b0;
	endtask : t_bits
	task automatic t_branch();
		logic [7:0] t[4] = '{8'h04, 8'h04, 8'h06, 8'h06};
		logic [7:0] h[4] = '{8'h02, 8'h00, 8'h00, 8'h00};
		logic [3:0] p[4] = '{4'h1, 4'h2, 4'h3, 4'h3};
		tk <= 1'b1;
		go(iet_pkg::IET_BRANCH, 1'b0, 6'h00);
		res(8'h08, 8'h02, 8'hFE, 4'h2, 4'h0);
		tk <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			bsz <= i[1:0];
			go(iet_pkg::IET_BRANCH, 1'b0, 6'h00);
			res(t[i], h[i], 8'h00, p[i], 4'h0);
		end
	endtask : t_branch
	task automatic t_decrement_and_branch_op();
		logic [7:0] t[6] = '{8'h04, 8'h06, 8'h0A, 8'h06, 8'h08, 8'h06};
		logic [7:0] h[6] = '{8'h01, 8'h02, 8'h06, 8'h04, 8'h06, 8'h06};
		logic [7:0] e[6] = '{8'h01, 8'h00, 8'hFE, 8'h00, 8'h00, 8'h00};
		logic [3:0] p[6] = '{4'h2, 4'h2, 4'h2, 4'h1, 4'h1, 4'h0};
		for (int i = 0; i < 6; i++) begin
			lp <= (i > 2);
			ct <= (i % 3 == 0);
			ex <= (i % 3 == 1);
			go(iet_pkg::IET_DEC_BRANCH, 1'b0, 6'h00);
			if (i < 3) res(t[i], h[i], e[i], p[i], 4'h0);
			else res(t[i], h[i], e[i], p[i], 4'h0);
		end
	endtask : t_decrement_and_branch_op
	task automatic t_stretch();
		sz <= iet_pkg::IET_SZ_BYTE;
		fork
			go(iet_pkg::IET_TEST_AND_SET, 1'b1, 6'h00);
			begin
				repeat (3) @(posedge clk_in);
				req <= 1'b1;
				@(posedge clk_in);
				req <= 1'b0;
			end
		join
		res(8'h0C, 8'h01, 8'h02, 4'h1, 4'h1);
	endtask : t_stretch
	initial begin
		repeat (3) @(posedge clk_in);
		check("reset total", tot, 8'h00);
		check("reset done", {7'h00, done}, 8'h00);
		resetn_in <= 1'b1;
		t_single();
		t_shift();
		t_bits();
		t_branch();
		t_decrement_and_branch_op();
		t_stretch();
		close_out();
	end
endmodule : instr_exec_cycle_timing_tb
`default_nettype wire
